// ==== include/mrd_pkg.sv ====
// Constants, encodings and types of the mid-range instruction decoder
package mrd_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int JUMP_W = 11;
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int BIT_W = 3;

  // Timing: core_clk is the oscillator, four periods per instruction
  localparam int CLK_MHZ = 50;
  localparam int OSC_PER_CYCLE = 4;
  localparam int REF_OSC_MHZ = 4;
  localparam int REF_CYCLE_NS = OSC_PER_CYCLE * 1000 / REF_OSC_MHZ;
  localparam int CYCLE_NS = OSC_PER_CYCLE * 1000 / CLK_MHZ;
  localparam int CYCLE_CLKS = CYCLE_NS * CLK_MHZ / 1000;
  localparam int PH_W = 2;
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_LATCH = 2'h2;
  localparam logic [1:0] PH_EXEC = 2'h3;

  // Prefix field [13:12]
  localparam logic [1:0] PFX_BYTE = 2'h0;
  localparam logic [1:0] PFX_BIT = 2'h1;
  localparam logic [1:0] PFX_CTRL = 2'h2;
  localparam logic [1:0] PFX_LIT = 2'h3;

  // Byte nibble field [11:8]
  localparam logic [3:0] NIB_MISC = 4'h0;
  localparam logic [3:0] NIB_CLR = 4'h1;
  localparam logic [3:0] NIB_SUB = 4'h2;
  localparam logic [3:0] NIB_DEC = 4'h3;
  localparam logic [3:0] NIB_OR = 4'h4;
  localparam logic [3:0] NIB_AND = 4'h5;
  localparam logic [3:0] NIB_XOR = 4'h6;
  localparam logic [3:0] NIB_ADD = 4'h7;
  localparam logic [3:0] NIB_MOV = 4'h8;
  localparam logic [3:0] NIB_COM = 4'h9;
  localparam logic [3:0] NIB_INC = 4'ha;
  localparam logic [3:0] NIB_DECSZ = 4'hb;
  localparam logic [3:0] NIB_RRC = 4'hc;
  localparam logic [3:0] NIB_RLC = 4'hd;
  localparam logic [3:0] NIB_SWAP = 4'he;
  localparam logic [3:0] NIB_INCSZ = 4'hf;

  // Bit sub-opcode [11:10]
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_TSC = 2'h2;
  localparam logic [1:0] BOP_TSS = 2'h3;

  // Literal group fields
  localparam logic [1:0] LIT_MOV = 2'h0;
  localparam logic [1:0] LIT_RET = 2'h1;
  localparam logic [2:0] LIT_SUB = 3'h6;
  localparam logic [2:0] LIT_ADD = 3'h7;
  localparam logic [3:0] LIT_OR = 4'h8;
  localparam logic [3:0] LIT_AND = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'ha;

  // Control words, low seven bits under nibble 0 with bit 7 clear
  localparam logic [6:0] LOW_RETURN = 7'h08;
  localparam logic [6:0] LOW_INT_RET = 7'h09;
  localparam logic [6:0] LOW_WDT_CLR = 7'h64;
  localparam logic [6:0] LOW_SLEEP = 7'h63;

  // Reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic RST_TO = 1'b1;
  localparam logic RST_PWR_DN = 1'b1;

  typedef enum logic [5:0] {
    OP_NO_OPERATION, OP_ADD_ACC_TO_FILE, OP_SUBTRACT_ACC_FROM_FILE,
    OP_AND_ACC_WITH_FILE, OP_OR_ACC_WITH_FILE, OP_XOR_ACC_WITH_FILE,
    OP_CLEAR_FILE, OP_CLEAR_ACC, OP_COMPLEMENT_FILE, OP_DECREMENT_FILE,
    OP_INCREMENT_FILE, OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO,
    OP_MOVE_FILE, OP_STORE_ACC_TO_FILE, OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY, OP_SWAP_FILE_NIBBLES, OP_BIT_CLEAR_OP,
    OP_BIT_SET_OP, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET,
    OP_ADD_LITERAL_OP, OP_LITERAL_MINUS_ACC_OP, OP_AND_LITERAL_OP,
    OP_OR_LITERAL_OP, OP_XOR_LITERAL_OP, OP_LOAD_LITERAL_OP,
    OP_RETURN_WITH_LITERAL, OP_SUB_CALL, OP_JUMP_OP, OP_SUB_RETURN,
    OP_INTERRUPT_RETURN, OP_WATCHDOG_CLEAR_OP, OP_SLEEP_ENTER
  } mrd_op_t;
endpackage : mrd_pkg

// ==== verilog/mrd_phase.sv ====
// Oscillator phase counter, four periods per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module mrd_phase #(
  parameter int PERIODS = mrd_pkg::OSC_PER_CYCLE,
  parameter int PW = mrd_pkg::PH_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic [PW-1:0] phase
);
  typedef struct packed {
    logic [PW-1:0] cnt;
  } mrd_phase_t;

  mrd_phase_t s;
  mrd_phase_t next_s;

  always_comb begin
    next_s = s;
    if (s.cnt == PW'(PERIODS - 1)) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + PW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign phase = s.cnt;
endmodule : mrd_phase
`default_nettype wire

// ==== verilog/mrd_decoder.sv ====
// Instruction decoder and sequencer of the 8-bit mid-range core
`timescale 1ns/1ps
`default_nettype none
module mrd_decoder (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [13:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pin_levels,
  input wire logic file_is_port,
  input wire logic file_is_timer,
  input wire logic presc_on_timer,
  output logic instr_fetch,
  output logic [6:0] file_addr,
  output logic file_rd,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic time_out_flag,
  output logic power_down_flag,
  output logic wdt_clear,
  output logic presc_clear,
  output logic pc_load,
  output logic [10:0] pc_target,
  output logic stack_push,
  output logic stack_pop,
  output logic int_return,
  output logic sleep_enter,
  output logic exec_nop
);
  typedef struct packed {
    logic [13:0] ir;
    logic [7:0] operand;
    logic flush;
    logic hold_pc;
    logic exec_nop;
    logic [7:0] acc;
    logic c;
    logic half_cy;
    logic z;
    logic to;
    logic pwr_dn;
    logic [6:0] file_addr;
    logic file_rd;
    logic file_we;
    logic [7:0] file_wdata;
    logic wdt_clear;
    logic presc_clear;
    logic pc_load;
    logic [10:0] pc_target;
    logic stack_push;
    logic stack_pop;
    logic int_return;
    logic sleep_enter;
    logic instr_fetch;
  } mrd_state_t;

  mrd_state_t s;
  mrd_state_t next_s;
  logic [1:0] phase;
  mrd_pkg::mrd_op_t op;
  logic lit_op;
  logic file_op;
  logic sub;
  logic [7:0] src;
  logic [7:0] addend;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] mask;
  logic [7:0] res;
  logic newc;
  logic dop;
  logic to_file;
  logic to_acc;
  logic upd_z;
  logic upd_cdc;
  logic skip;
  logic branch;

  mrd_phase #(
    .PERIODS(mrd_pkg::OSC_PER_CYCLE),
    .PW(mrd_pkg::PH_W)
  ) u_phase (
    .core_clk(core_clk),
    .nrst(nrst),
    .phase(phase)
  );

  always_comb begin
    next_s = s;
    op = mrd_pkg::OP_NO_OPERATION;
    // Decode the held word
    case (s.ir[13:12])
      mrd_pkg::PFX_BYTE: begin
        case (s.ir[11:8])
          mrd_pkg::NIB_MISC: begin
            if (s.ir[mrd_pkg::DEST_POS]) begin
              op = mrd_pkg::OP_STORE_ACC_TO_FILE;
            end else if (s.ir[6:0] == mrd_pkg::LOW_RETURN) begin
              op = mrd_pkg::OP_SUB_RETURN;
            end else if (s.ir[6:0] == mrd_pkg::LOW_INT_RET) begin
              op = mrd_pkg::OP_INTERRUPT_RETURN;
            end else if (s.ir[6:0] == mrd_pkg::LOW_WDT_CLR) begin
              op = mrd_pkg::OP_WATCHDOG_CLEAR_OP;
            end else if (s.ir[6:0] == mrd_pkg::LOW_SLEEP) begin
              op = mrd_pkg::OP_SLEEP_ENTER;
            end else begin
              op = mrd_pkg::OP_NO_OPERATION;
            end
          end
          mrd_pkg::NIB_CLR: op = s.ir[mrd_pkg::DEST_POS] ?
            mrd_pkg::OP_CLEAR_FILE : mrd_pkg::OP_CLEAR_ACC;
          mrd_pkg::NIB_SUB: op = mrd_pkg::OP_SUBTRACT_ACC_FROM_FILE;
          mrd_pkg::NIB_DEC: op = mrd_pkg::OP_DECREMENT_FILE;
          mrd_pkg::NIB_OR: op = mrd_pkg::OP_OR_ACC_WITH_FILE;
          mrd_pkg::NIB_AND: op = mrd_pkg::OP_AND_ACC_WITH_FILE;
          mrd_pkg::NIB_XOR: op = mrd_pkg::OP_XOR_ACC_WITH_FILE;
          mrd_pkg::NIB_ADD: op = mrd_pkg::OP_ADD_ACC_TO_FILE;
          mrd_pkg::NIB_MOV: op = mrd_pkg::OP_MOVE_FILE;
          mrd_pkg::NIB_COM: op = mrd_pkg::OP_COMPLEMENT_FILE;
          mrd_pkg::NIB_INC: op = mrd_pkg::OP_INCREMENT_FILE;
          mrd_pkg::NIB_DECSZ: op = mrd_pkg::OP_DECREMENT_SKIP_ZERO;
          mrd_pkg::NIB_RRC: op = mrd_pkg::OP_ROTATE_RIGHT_CARRY;
          mrd_pkg::NIB_RLC: op = mrd_pkg::OP_ROTATE_LEFT_CARRY;
          mrd_pkg::NIB_SWAP: op = mrd_pkg::OP_SWAP_FILE_NIBBLES;
          default: op = mrd_pkg::OP_INCREMENT_SKIP_ZERO;
        endcase
      end
      mrd_pkg::PFX_BIT: begin
        case (s.ir[11:10])
          mrd_pkg::BOP_CLR: op = mrd_pkg::OP_BIT_CLEAR_OP;
          mrd_pkg::BOP_SET: op = mrd_pkg::OP_BIT_SET_OP;
          mrd_pkg::BOP_TSC: op = mrd_pkg::OP_TEST_SKIP_IF_CLEAR;
          default: op = mrd_pkg::OP_TEST_SKIP_IF_SET;
        endcase
      end
      mrd_pkg::PFX_CTRL: op = s.ir[11] ?
        mrd_pkg::OP_JUMP_OP : mrd_pkg::OP_SUB_CALL;
      default: begin
        if (s.ir[11:10] == mrd_pkg::LIT_MOV) begin
          op = mrd_pkg::OP_LOAD_LITERAL_OP;
        end else if (s.ir[11:10] == mrd_pkg::LIT_RET) begin
          op = mrd_pkg::OP_RETURN_WITH_LITERAL;
        end else if (s.ir[11:9] == mrd_pkg::LIT_ADD) begin
          op = mrd_pkg::OP_ADD_LITERAL_OP;
        end else if (s.ir[11:9] == mrd_pkg::LIT_SUB) begin
          op = mrd_pkg::OP_LITERAL_MINUS_ACC_OP;
        end else if (s.ir[11:8] == mrd_pkg::LIT_OR) begin
          op = mrd_pkg::OP_OR_LITERAL_OP;
        end else if (s.ir[11:8] == mrd_pkg::LIT_AND) begin
          op = mrd_pkg::OP_AND_LITERAL_OP;
        end else if (s.ir[11:8] == mrd_pkg::LIT_XOR) begin
          op = mrd_pkg::OP_XOR_LITERAL_OP;
        end else begin
          op = mrd_pkg::OP_NO_OPERATION;
        end
      end
    endcase

    // Shared arithmetic
    lit_op = (s.ir[13:12] == mrd_pkg::PFX_LIT);
    file_op = (s.ir[13:12] == mrd_pkg::PFX_BIT) ||
      ((s.ir[13:12] == mrd_pkg::PFX_BYTE) &&
      (op != mrd_pkg::OP_CLEAR_ACC) &&
      ((s.ir[11:8] != mrd_pkg::NIB_MISC) || s.ir[mrd_pkg::DEST_POS]));
    sub = (op == mrd_pkg::OP_SUBTRACT_ACC_FROM_FILE) ||
      (op == mrd_pkg::OP_LITERAL_MINUS_ACC_OP);
    src = lit_op ? s.ir[7:0] : s.operand;
    addend = sub ? ~s.acc : s.acc;
    sum = {1'b0, src} + {1'b0, addend} + {8'h00, sub};
    half = {1'b0, src[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
    mask = 8'h01 << s.ir[9:mrd_pkg::BIT_LSB];
    res = src;
    newc = s.c;
    dop = 1'b0;
    to_file = 1'b0;
    to_acc = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    skip = 1'b0;
    branch = 1'b0;

    // One-cycle pulses
    next_s.file_rd = 1'b0;
    next_s.file_we = 1'b0;
    next_s.wdt_clear = 1'b0;
    next_s.presc_clear = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.stack_push = 1'b0;
    next_s.stack_pop = 1'b0;
    next_s.int_return = 1'b0;
    next_s.sleep_enter = 1'b0;
    next_s.instr_fetch = 1'b0;

    case (phase)
      mrd_pkg::PH_FETCH: begin
        next_s.ir = s.flush ? '0 : instr;
        next_s.exec_nop = s.flush;
        next_s.flush = 1'b0;
      end
      mrd_pkg::PH_READ: begin
        next_s.file_addr = s.ir[mrd_pkg::ADDR_W-1:0];
        next_s.file_rd = file_op;
      end
      mrd_pkg::PH_LATCH: begin
        next_s.operand = file_is_port ? pin_levels : file_rdata;
      end
      default: begin
        case (op)
          mrd_pkg::OP_ADD_ACC_TO_FILE, mrd_pkg::OP_SUBTRACT_ACC_FROM_FILE,
          mrd_pkg::OP_ADD_LITERAL_OP, mrd_pkg::OP_LITERAL_MINUS_ACC_OP:
          begin
            res = sum[7:0];
            upd_cdc = 1'b1;
            upd_z = 1'b1;
            dop = 1'b1;
          end
          mrd_pkg::OP_AND_ACC_WITH_FILE, mrd_pkg::OP_AND_LITERAL_OP: begin
            res = src & s.acc;
            upd_z = 1'b1;
            dop = 1'b1;
          end
          mrd_pkg::OP_OR_ACC_WITH_FILE, mrd_pkg::OP_OR_LITERAL_OP: begin
            res = src | s.acc;
            upd_z = 1'b1;
            dop = 1'b1;
          end
          mrd_pkg::OP_XOR_ACC_WITH_FILE, mrd_pkg::OP_XOR_LITERAL_OP: begin
            res = src ^ s.acc;
            upd_z = 1'b1;
            dop = 1'b1;
          end
          mrd_pkg::OP_CLEAR_FILE: begin
            res = 8'h00;
            upd_z = 1'b1;
            to_file = 1'b1;
          end
          mrd_pkg::OP_CLEAR_ACC: begin
            res = 8'h00;
            upd_z = 1'b1;
            to_acc = 1'b1;
          end
          mrd_pkg::OP_COMPLEMENT_FILE: begin
            res = ~src;
            upd_z = 1'b1;
            dop = 1'b1;
          end
          mrd_pkg::OP_DECREMENT_FILE, mrd_pkg::OP_INCREMENT_FILE: begin
            res = (op == mrd_pkg::OP_INCREMENT_FILE) ?
              src + 8'h01 : src - 8'h01;
            upd_z = 1'b1;
            dop = 1'b1;
          end
          mrd_pkg::OP_DECREMENT_SKIP_ZERO,
          mrd_pkg::OP_INCREMENT_SKIP_ZERO: begin
            res = (op == mrd_pkg::OP_INCREMENT_SKIP_ZERO) ?
              src + 8'h01 : src - 8'h01;
            skip = (res == 8'h00);
            dop = 1'b1;
          end
          mrd_pkg::OP_MOVE_FILE: begin
            upd_z = 1'b1;
            dop = 1'b1;
          end
          mrd_pkg::OP_STORE_ACC_TO_FILE: begin
            res = s.acc;
            to_file = 1'b1;
          end
          mrd_pkg::OP_ROTATE_LEFT_CARRY: begin
            res = {src[6:0], s.c};
            newc = src[7];
            dop = 1'b1;
          end
          mrd_pkg::OP_ROTATE_RIGHT_CARRY: begin
            res = {s.c, src[7:1]};
            newc = src[0];
            dop = 1'b1;
          end
          mrd_pkg::OP_SWAP_FILE_NIBBLES: begin
            res = {src[3:0], src[7:4]};
            dop = 1'b1;
          end
          mrd_pkg::OP_BIT_CLEAR_OP: begin
            res = src & ~mask;
            to_file = 1'b1;
          end
          mrd_pkg::OP_BIT_SET_OP: begin
            res = src | mask;
            to_file = 1'b1;
          end
          mrd_pkg::OP_TEST_SKIP_IF_CLEAR: skip = ~|(src & mask);
          mrd_pkg::OP_TEST_SKIP_IF_SET: skip = |(src & mask);
          mrd_pkg::OP_LOAD_LITERAL_OP: to_acc = 1'b1;
          mrd_pkg::OP_RETURN_WITH_LITERAL: begin
            to_acc = 1'b1;
            branch = 1'b1;
            next_s.stack_pop = 1'b1;
          end
          mrd_pkg::OP_SUB_CALL, mrd_pkg::OP_JUMP_OP: begin
            branch = 1'b1;
            next_s.pc_load = 1'b1;
            next_s.pc_target = s.ir[mrd_pkg::JUMP_W-1:0];
            next_s.stack_push = (op == mrd_pkg::OP_SUB_CALL);
          end
          mrd_pkg::OP_SUB_RETURN, mrd_pkg::OP_INTERRUPT_RETURN: begin
            branch = 1'b1;
            next_s.stack_pop = 1'b1;
            next_s.int_return = (op == mrd_pkg::OP_INTERRUPT_RETURN);
          end
          mrd_pkg::OP_WATCHDOG_CLEAR_OP: begin
            next_s.wdt_clear = 1'b1;
            next_s.to = 1'b1;
            next_s.pwr_dn = 1'b1;
          end
          mrd_pkg::OP_SLEEP_ENTER: begin
            next_s.wdt_clear = 1'b1;
            next_s.to = 1'b1;
            next_s.pwr_dn = 1'b0;
            next_s.sleep_enter = 1'b1;
          end
          default: res = src;
        endcase
        if (dop) begin
          if (lit_op) begin
            to_acc = 1'b1;
          end else begin
            to_file = s.ir[mrd_pkg::DEST_POS];
            to_acc = !s.ir[mrd_pkg::DEST_POS];
          end
        end
        if (to_acc) begin
          next_s.acc = res;
        end
        if (to_file) begin
          next_s.file_we = 1'b1;
          next_s.file_wdata = res;
          next_s.presc_clear = file_is_timer && presc_on_timer &&
            (op != mrd_pkg::OP_STORE_ACC_TO_FILE);
        end
        next_s.c = newc;
        if (upd_cdc) begin
          next_s.c = sum[8];
          next_s.half_cy = half[4];
        end
        if (upd_z) begin
          next_s.z = (res == 8'h00);
        end
        next_s.flush = skip || branch;
        next_s.hold_pc = branch;
        next_s.instr_fetch = !branch && !s.hold_pc;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.acc <= mrd_pkg::RST_ACC;
      s.to <= mrd_pkg::RST_TO;
      s.pwr_dn <= mrd_pkg::RST_PWR_DN;
    end else begin
      s <= next_s;
    end
  end

  assign instr_fetch = s.instr_fetch;
  assign file_addr = s.file_addr;
  assign file_rd = s.file_rd;
  assign file_we = s.file_we;
  assign file_wdata = s.file_wdata;
  assign acc = s.acc;
  assign carry_flag = s.c;
  assign digit_carry_flag = s.half_cy;
  assign zero_flag = s.z;
  assign time_out_flag = s.to;
  assign power_down_flag = s.pwr_dn;
  assign wdt_clear = s.wdt_clear;
  assign presc_clear = s.presc_clear;
  assign pc_load = s.pc_load;
  assign pc_target = s.pc_target;
  assign stack_push = s.stack_push;
  assign stack_pop = s.stack_pop;
  assign int_return = s.int_return;
  assign sleep_enter = s.sleep_enter;
  assign exec_nop = s.exec_nop;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic ex;
  assign ex = (phase == mrd_pkg::PH_EXEC);

  cycle_len_a: assert property (
    ex |=> !ex [*3] ##1 ex)
    else $error("instruction cycle is not four clocks");
  rmw_read_a: assert property (
    s.file_we |-> $past(s.file_rd, 2))
    else $error("file write without prior read");
  acc_dest_a: assert property (
    (ex && s.ir[13:12] == mrd_pkg::PFX_BYTE && !s.ir[7]) |=> !s.file_we)
    else $error("destination zero wrote the file");
  file_dest_a: assert property (
    (ex && s.ir[13:12] == mrd_pkg::PFX_BYTE && s.ir[7])
    |=> s.file_we && s.file_addr == $past(s.ir[6:0]))
    else $error("destination one did not write the file");
  port_read_a: assert property (
    (phase == mrd_pkg::PH_LATCH && file_is_port && s.file_rd)
    |=> s.operand == $past(pin_levels))
    else $error("port read not taken from pins");
  presc_a: assert property (
    s.presc_clear |-> s.file_we && $past(file_is_timer && presc_on_timer))
    else $error("prescaler cleared without timer write");
  zero_a: assert property (
    (ex && upd_z) |=>
    s.z == ((s.file_we ? s.file_wdata : s.acc) == 8'h00))
    else $error("zero flag does not match result");
  swap_a: assert property (
    (ex && op == mrd_pkg::OP_SWAP_FILE_NIBBLES)
    |=> $stable({s.c, s.half_cy, s.z}))
    else $error("swap changed a flag");
  skip_a: assert property (
    (ex && skip) |=> ##1 s.exec_nop [*4])
    else $error("skip did not insert a no-op cycle");
  sleep_a: assert property (
    (ex && op == mrd_pkg::OP_SLEEP_ENTER)
    |=> s.to && !s.pwr_dn && s.wdt_clear && s.sleep_enter)
    else $error("sleep flags wrong");
  jump_a: assert property (
    (ex && op == mrd_pkg::OP_JUMP_OP)
    |=> s.pc_load && s.pc_target == $past(s.ir[10:0]) ##4 !s.instr_fetch)
    else $error("jump target or hold wrong");
  bit_set_a: assert property (
    (ex && op == mrd_pkg::OP_BIT_SET_OP)
    |=> s.file_wdata[$past(s.ir[9:7])])
    else $error("bit set missed the chosen bit");

  skip_c: cover property (ex && skip);
  sleep_c: cover property (ex && op == mrd_pkg::OP_SLEEP_ENTER);
  call_c: cover property (ex && op == mrd_pkg::OP_SUB_CALL);
  port_c: cover property (phase == mrd_pkg::PH_LATCH && file_is_port);
endmodule : mrd_decoder
`default_nettype wire

// ==== bench/mrd_prog_mem.sv ====
// Program memory model that presents the word at the program counter
`timescale 1ns/1ps
`default_nettype none
module mrd_prog_mem (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic instr_fetch,
  input wire logic pc_load,
  input wire logic [10:0] pc_target,
  input wire logic stack_push,
  input wire logic stack_pop,
  output logic [13:0] instr
);
  logic [13:0] rom [0:2047];
  logic [10:0] pc;
  logic [10:0] ret;
  logic [10:0] addr;
  initial for (int i = 0; i < 2048; i++) rom[i] = 14'h0000;
  // Next word shows as soon as the core asks for it
  always_comb begin
    addr = pc;
    if (instr_fetch) addr = pc + 11'h001;
    if (pc_load) addr = pc_target;
    if (stack_pop) addr = ret;
  end
  assign instr = rom[addr];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pc <= 11'h000;
      ret <= 11'h000;
    end else begin
      pc <= addr;
      if (stack_push) ret <= pc + 11'h001;
    end
  end
endmodule : mrd_prog_mem
`default_nettype wire

// ==== bench/test_mrd_decoder.sv ====
// Self-checking bench of the mid-range instruction decoder
`timescale 1ns/1ps
`default_nettype none
module test_mrd_decoder;
  logic core_clk, nrst, file_is_port, file_is_timer, presc_on_timer;
  logic [13:0] instr;
  logic [7:0] file_rdata, pin_levels, acc, file_wdata;
  logic instr_fetch, file_rd, file_we, carry_flag, digit_carry_flag;
  logic zero_flag, time_out_flag, power_down_flag, wdt_clear, presc_clear;
  logic pc_load, stack_push, stack_pop, int_return, sleep_enter, exec_nop;
  logic [6:0] file_addr;
  logic [10:0] pc_target;
  int err_count = 0;
  int checked = 0;
  mrd_decoder dut (.core_clk(core_clk), .nrst(nrst), .instr(instr),
    .file_rdata(file_rdata), .pin_levels(pin_levels),
    .file_is_port(file_is_port), .file_is_timer(file_is_timer),
    .presc_on_timer(presc_on_timer), .instr_fetch(instr_fetch),
    .file_addr(file_addr), .file_rd(file_rd), .file_we(file_we),
    .file_wdata(file_wdata), .acc(acc), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .time_out_flag(time_out_flag), .power_down_flag(power_down_flag),
    .wdt_clear(wdt_clear), .presc_clear(presc_clear), .pc_load(pc_load),
    .pc_target(pc_target), .stack_push(stack_push), .stack_pop(stack_pop),
    .int_return(int_return), .sleep_enter(sleep_enter),
    .exec_nop(exec_nop));
  mrd_prog_mem pm (.core_clk(core_clk), .nrst(nrst),
    .instr_fetch(instr_fetch), .pc_load(pc_load), .pc_target(pc_target),
    .stack_push(stack_push), .stack_pop(stack_pop), .instr(instr));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [15:0] s,
      input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Places one word, holds file inputs, returns in next phase 0
  task automatic issue(input logic [13:0] w, input logic [7:0] d,
      input logic [7:0] pins, input logic [2:0] sel);
    pm.rom[pm.addr] = w;
    @(posedge core_clk);
    file_rdata <= d;
    pin_levels <= pins;
    {file_is_port, file_is_timer, presc_on_timer} <= sel;
    repeat (4) @(negedge core_clk);
  endtask : issue
  function automatic logic [15:0] flags;
    return {13'h0000, carry_flag, digit_carry_flag, zero_flag};
  endfunction : flags
  task automatic t_literal;
    issue(14'h335a, 8'h00, 8'h00, 3'h0);
    chk("acc", acc, 16'h5a);
    issue(14'h3ea6, 8'h00, 8'h00, 3'h0);
    chk("acc", acc, 16'h00);
    chk("flags", flags(), 16'h7);
    issue(14'h3b00, 8'h00, 8'h00, 3'h0);
    chk("acc", acc, 16'h00);
    chk("file_we", file_we, 16'h0);
  endtask : t_literal
  task automatic t_byte;
    issue(14'h07ff, 8'h01, 8'h00, 3'h0);
    chk("file_we", file_we, 16'h1);
    chk("file_addr", file_addr, 16'h7f);
    chk("file_wdata", file_wdata, 16'h01);
    chk("flags", flags(), 16'h0);
    issue(14'h0200, 8'h03, 8'h00, 3'h0);
    chk("acc", acc, 16'h03);
    chk("file_we", file_we, 16'h0);
    chk("flags", flags(), 16'h6);
    issue(14'h0886, 8'hff, 8'h0c, 3'h4);
    chk("file_wdata", file_wdata, 16'h0c);
  endtask : t_byte
  task automatic t_timer;
    issue(14'h0181, 8'h5a, 8'h00, 3'h3);
    chk("file_wdata", file_wdata, 16'h00);
    chk("presc_clear", presc_clear, 16'h1);
    chk("flags", flags(), 16'h7);
    issue(14'h0181, 8'h5a, 8'h00, 3'h2);
    chk("presc_clear", presc_clear, 16'h0);
  endtask : t_timer
  task automatic t_bits;
    issue(14'h1790, 8'h00, 8'h00, 3'h0);
    chk("file_wdata", file_wdata, 16'h80);
    issue(14'h1010, 8'hff, 8'h00, 3'h0);
    chk("file_wdata", file_wdata, 16'hfe);
    issue(14'h0d00, 8'h40, 8'h00, 3'h0);
    chk("acc", acc, 16'h81);
    chk("flags", flags(), 16'h3);
  endtask : t_bits
  task automatic t_skip;
    issue(14'h1d90, 8'h08, 8'h00, 3'h0);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h1);
    issue(14'h1990, 8'h08, 8'h00, 3'h0);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h0);
    issue(14'h0b81, 8'h02, 8'h00, 3'h0);
    chk("file_wdata", file_wdata, 16'h01);
    chk("flags", flags(), 16'h3);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h0);
    issue(14'h0f81, 8'hff, 8'h00, 3'h0);
    chk("file_wdata", file_wdata, 16'h00);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h1);
  endtask : t_skip
  task automatic t_ctrl;
    issue(14'h2923, 8'h00, 8'h00, 3'h0);
    chk("pc_load", pc_load, 16'h1);
    chk("pc_target", pc_target, 16'h123);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h1);
    issue(14'h3477, 8'h00, 8'h00, 3'h0);
    chk("acc", acc, 16'h77);
    chk("stack_pop", stack_pop, 16'h1);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h1);
    issue(14'h0063, 8'h00, 8'h00, 3'h0);
    chk("sleep_enter", sleep_enter, 16'h1);
    chk("wdt_clear", wdt_clear, 16'h1);
    chk("to_pd", {time_out_flag, power_down_flag}, 16'h2);
    issue(14'h0064, 8'h00, 8'h00, 3'h0);
    chk("wdt_clear", wdt_clear, 16'h1);
    chk("to_pd", {time_out_flag, power_down_flag}, 16'h3);
  endtask : t_ctrl
  task automatic t_flow;
    issue(14'h2005, 8'h00, 8'h00, 3'h0);
    chk("call", {pc_load, stack_push, pc_target}, 16'h1805);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h1);
    issue(14'h0008, 8'h00, 8'h00, 3'h0);
    chk("return", {stack_pop, int_return}, 16'h2);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h1);
    issue(14'h0009, 8'h00, 8'h00, 3'h0);
    chk("return", {stack_pop, int_return}, 16'h3);
    issue(14'h0000, 8'h00, 8'h00, 3'h0);
    chk("exec_nop", exec_nop, 16'h1);
    issue(14'h3a0f, 8'h00, 8'h00, 3'h0);
    chk("acc", acc, 16'h78);
    chk("flags", flags(), 16'h2);
    issue(14'h017f, 8'h00, 8'h00, 3'h0);
    chk("acc", acc, 16'h00);
    chk("file_we", file_we, 16'h0);
    chk("flags", flags(), 16'h3);
    pm.rom[pm.addr] = 14'h0e85;
    @(posedge core_clk);
    file_rdata <= 8'h3c;
    repeat (2) @(negedge core_clk);
    chk("file_rd", {file_rd, file_addr}, 16'h85);
    repeat (2) @(negedge core_clk);
    chk("file_wdata", file_wdata, 16'hc3);
    chk("flags", flags(), 16'h3);
    issue(14'h3c00, 8'h00, 8'h00, 3'h0);
    chk("acc", acc, 16'h00);
    chk("flags", flags(), 16'h7);
  endtask : t_flow
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    {nrst, file_is_port, file_is_timer, presc_on_timer} = 4'h0;
    file_rdata = 8'h00;
    pin_levels = 8'h00;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    t_literal();
    t_byte();
    t_timer();
    t_bits();
    t_skip();
    t_ctrl();
    t_flow();
    test_done();
  end
endmodule : test_mrd_decoder
`default_nettype wire
